/* File: hdl/dpakw_cfg.svh */
`ifndef DPAKW_CFG_SVH
`define DPAKW_CFG_SVH
// register byte offsets
`define DPAKW_OFF_A_LATCH    12'h000
`define DPAKW_OFF_A_DIR      12'h004
`define DPAKW_OFF_A_INEN     12'h008
`define DPAKW_OFF_A_WAKE     12'h00c
`define DPAKW_OFF_B_LATCH    12'h010
`define DPAKW_OFF_B_DIR      12'h014
`define DPAKW_OFF_B_INEN     12'h018
// reset values
`define DPAKW_RST_LATCH      8'h00
`define DPAKW_RST_DIR        8'h00
`define DPAKW_RST_INEN       8'hff
`define DPAKW_RST_WAKE       8'h00
// ahb encodings
`define DPAKW_HTRANS_NONSEQ  2'h2
`define DPAKW_HTRANS_SEQ     2'h3
`define DPAKW_ADDR_BITS      12
`endif

/* File: hdl/dpakw_pkg.sv */
package dpakw_pkg;
   // register selector decoded from the bus address
   typedef enum logic [7:0] {
      DPAKW_SEL_NONE    = 8'h01,
      DPAKW_SEL_A_LATCH = 8'h02,
      DPAKW_SEL_A_DIR   = 8'h04,
      DPAKW_SEL_A_INEN  = 8'h08,
      DPAKW_SEL_A_WAKE  = 8'h10,
      DPAKW_SEL_B_LATCH = 8'h20,
      DPAKW_SEL_B_DIR   = 8'h40,
      DPAKW_SEL_B_INEN  = 8'h80
   } dpakw_sel_t;
endpackage

/* File: hdl/dpakw_io.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpakw_cfg.svh"

// Function
// - two ports of eight pins, each pin's direction chosen on its own
// - reset clears direction and latches, sets input enables, all pins inputs
// - direction bit 1 makes the pin an output
// - analog: input enable 0 cuts the pin's digital input path
// - data read gives latch contents for output-direction bits
// - input-direction read gives pin level if enabled, else zero
// - read-modify-write puts sampled pin levels into input-bit latches
// - second port has analog only, no wakeup enable
module dpakw_io
   import dpakw_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic [7:0]  port_a_pin_in,
   input  wire logic [7:0]  port_b_pin_in,
   output logic      [7:0]  port_a_pin_out,
   output logic      [7:0]  port_a_pin_oe_out,
   output logic      [7:0]  port_b_pin_out,
   output logic      [7:0]  port_b_pin_oe_out,
   output logic      [7:0]  port_a_digital_en_out,
   output logic      [7:0]  port_b_digital_en_out,
   output logic      [7:0]  key_wakeup_enable_out
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (WIDTH != 8) begin : g_bad_width
      $error("dpakw_io supports only 8-bit ports");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // address decode, used for the data phase selector
   function automatic dpakw_sel_t decode(input logic [`DPAKW_ADDR_BITS-1:0] a);
      case (a)
         `DPAKW_OFF_A_LATCH: decode = DPAKW_SEL_A_LATCH;
         `DPAKW_OFF_A_DIR:   decode = DPAKW_SEL_A_DIR;
         `DPAKW_OFF_A_INEN:  decode = DPAKW_SEL_A_INEN;
         `DPAKW_OFF_A_WAKE:  decode = DPAKW_SEL_A_WAKE;
         `DPAKW_OFF_B_LATCH: decode = DPAKW_SEL_B_LATCH;
         `DPAKW_OFF_B_DIR:   decode = DPAKW_SEL_B_DIR;
         `DPAKW_OFF_B_INEN:  decode = DPAKW_SEL_B_INEN;
         default:            decode = DPAKW_SEL_NONE;
      endcase
   endfunction

   // per-bit data read: latch for outputs, gated pin for inputs
   function automatic logic [7:0] data_view(input logic [7:0] latch, input logic [7:0] dir,
                                            input logic [7:0] inen, input logic [7:0] pin);
      data_view = (dir & latch) | (~dir & inen & pin);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] port_a_output_latch;
   logic [7:0] port_a_direction;
   logic [7:0] port_a_input_enable;
   logic [7:0] key_wakeup_enable;
   logic [7:0] port_b_output_latch;
   logic [7:0] port_b_direction;
   logic [7:0] port_b_input_enable;
   dpakw_sel_t wr_sel;
   logic       wr_pend;
   logic [31:0] hrdata;
   logic [7:0] port_a_digital_en;
   logic [7:0] port_b_digital_en;
   logic [7:0] next_port_a_digital_en;
   logic [7:0] next_port_b_digital_en;

   logic [7:0] next_port_a_output_latch;
   logic [7:0] next_port_a_direction;
   logic [7:0] next_port_a_input_enable;
   logic [7:0] next_key_wakeup_enable;
   logic [7:0] next_port_b_output_latch;
   logic [7:0] next_port_b_direction;
   logic [7:0] next_port_b_input_enable;
   dpakw_sel_t next_wr_sel;
   logic       next_wr_pend;
   logic [31:0] next_hrdata;
   logic       addr_valid;
   dpakw_sel_t addr_sel;

   assign addr_valid = hsel_in && hready_in &&
                       (htrans_in == `DPAKW_HTRANS_NONSEQ || htrans_in == `DPAKW_HTRANS_SEQ);
   assign addr_sel   = decode(haddr_in[`DPAKW_ADDR_BITS-1:0]);

   // ----------------------------------------------------------------
   // bus and register next values
   // ----------------------------------------------------------------
   // address phase captures target; data phase writes; reads are registered
   always_comb begin
      next_port_a_output_latch = port_a_output_latch;
      next_port_a_direction    = port_a_direction;
      next_port_a_input_enable = port_a_input_enable;
      next_key_wakeup_enable   = key_wakeup_enable;
      next_port_b_output_latch = port_b_output_latch;
      next_port_b_direction    = port_b_direction;
      next_port_b_input_enable = port_b_input_enable;
      next_wr_pend             = 1'b0;
      next_wr_sel              = DPAKW_SEL_NONE;
      next_hrdata              = hrdata;
      if (wr_pend) begin
         // a full byte write stores the whole latch; a read-modify-write thus
         // carries sampled pin levels into input-mode latches
         case (wr_sel)
            DPAKW_SEL_A_LATCH: next_port_a_output_latch = hwdata_in[7:0];
            DPAKW_SEL_A_DIR:   next_port_a_direction    = hwdata_in[7:0];
            DPAKW_SEL_A_INEN:  next_port_a_input_enable = hwdata_in[7:0];
            DPAKW_SEL_A_WAKE:  next_key_wakeup_enable   = hwdata_in[7:0];
            DPAKW_SEL_B_LATCH: next_port_b_output_latch = hwdata_in[7:0];
            DPAKW_SEL_B_DIR:   next_port_b_direction    = hwdata_in[7:0];
            DPAKW_SEL_B_INEN:  next_port_b_input_enable = hwdata_in[7:0];
            default: begin
            end
         endcase
      end
      if (addr_valid && hwrite_in) begin
         next_wr_pend = 1'b1;
         next_wr_sel  = addr_sel;
      end else if (addr_valid) begin
         case (addr_sel)
            DPAKW_SEL_A_LATCH: next_hrdata = {24'h000000,
               data_view(port_a_output_latch, port_a_direction, port_a_input_enable, port_a_pin_in)};
            DPAKW_SEL_A_DIR:   next_hrdata = {24'h000000, port_a_direction};
            DPAKW_SEL_A_INEN:  next_hrdata = {24'h000000, port_a_input_enable};
            DPAKW_SEL_A_WAKE:  next_hrdata = {24'h000000, key_wakeup_enable};
            DPAKW_SEL_B_LATCH: next_hrdata = {24'h000000,
               data_view(port_b_output_latch, port_b_direction, port_b_input_enable, port_b_pin_in)};
            DPAKW_SEL_B_DIR:   next_hrdata = {24'h000000, port_b_direction};
            DPAKW_SEL_B_INEN:  next_hrdata = {24'h000000, port_b_input_enable};
            default:           next_hrdata = 32'h00000000;
         endcase
      end
      // digital input path open only for inputs with enable set, taken from next values
      next_port_a_digital_en = ~next_port_a_direction & next_port_a_input_enable;
      next_port_b_digital_en = ~next_port_b_direction & next_port_b_input_enable;
   end

   // register update
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         port_a_output_latch <= `DPAKW_RST_LATCH;
         port_a_direction    <= `DPAKW_RST_DIR;
         port_a_input_enable <= `DPAKW_RST_INEN;
         key_wakeup_enable   <= `DPAKW_RST_WAKE;
         port_b_output_latch <= `DPAKW_RST_LATCH;
         port_b_direction    <= `DPAKW_RST_DIR;
         port_b_input_enable <= `DPAKW_RST_INEN;
         wr_pend             <= 1'b0;
         wr_sel              <= DPAKW_SEL_NONE;
         hrdata              <= 32'h00000000;
         port_a_digital_en   <= ~`DPAKW_RST_DIR & `DPAKW_RST_INEN;
         port_b_digital_en   <= ~`DPAKW_RST_DIR & `DPAKW_RST_INEN;
      end else begin
         port_a_output_latch <= next_port_a_output_latch;
         port_a_direction    <= next_port_a_direction;
         port_a_input_enable <= next_port_a_input_enable;
         key_wakeup_enable   <= next_key_wakeup_enable;
         port_b_output_latch <= next_port_b_output_latch;
         port_b_direction    <= next_port_b_direction;
         port_b_input_enable <= next_port_b_input_enable;
         wr_pend             <= next_wr_pend;
         wr_sel              <= next_wr_sel;
         hrdata              <= next_hrdata;
         port_a_digital_en   <= next_port_a_digital_en;
         port_b_digital_en   <= next_port_b_digital_en;
      end
   end

   // ----------------------------------------------------------------
   // outputs, from flip-flops except the tied-off hreadyout and hresp
   // ----------------------------------------------------------------
   assign hrdata_out            = hrdata;
   assign hreadyout_out         = 1'b1; // zero wait states
   assign hresp_out             = 1'b0;
   assign port_a_pin_out        = port_a_output_latch;
   assign port_a_pin_oe_out     = port_a_direction;
   assign port_b_pin_out        = port_b_output_latch;
   assign port_b_pin_oe_out     = port_b_direction;
   // digital path enables, registered
   assign port_a_digital_en_out = port_a_digital_en;
   assign port_b_digital_en_out = port_b_digital_en;
   assign key_wakeup_enable_out = key_wakeup_enable;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_write_dir_a;
      addr_valid && hwrite_in && addr_sel == DPAKW_SEL_A_DIR;
   endsequence

   a_oe_follows_dir: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_write_dir_a ##1 1'b1 |=> port_a_pin_oe_out == $past(hwdata_in[7:0]))
      else $error("port a enable did not follow direction write");
   a_reset_inputs: assert property (@(posedge clk_in)
      $rose(rstn_in) |-> port_a_pin_oe_out == 8'h00 && port_b_pin_oe_out == 8'h00
                         && port_a_digital_en_out == 8'hff)
      else $error("pins not inputs after reset");
   a_pin_drive_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
      wr_pend && wr_sel == DPAKW_SEL_A_LATCH |=> port_a_pin_out == $past(hwdata_in[7:0]))
      else $error("pin drive differs from written latch");
   a_read_output_bits: assert property (@(posedge clk_in) disable iff (!rstn_in)
      addr_valid && !hwrite_in && addr_sel == DPAKW_SEL_A_LATCH && !wr_pend
      |=> (hrdata_out[7:0] & $past(port_a_direction)) ==
          ($past(port_a_output_latch) & $past(port_a_direction)))
      else $error("read of output bits not latch");
   a_read_analog_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
      addr_valid && !hwrite_in && addr_sel == DPAKW_SEL_B_LATCH && !wr_pend
      |=> (hrdata_out[7:0] & ~$past(port_b_direction) & ~$past(port_b_input_enable)) == 8'h00)
      else $error("analog bit read not zero");
   a_read_pin_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
      addr_valid && !hwrite_in && addr_sel == DPAKW_SEL_A_LATCH && !wr_pend
      |=> (hrdata_out[7:0] & ~$past(port_a_direction) & $past(port_a_input_enable)) ==
          ($past(port_a_pin_in) & ~$past(port_a_direction) & $past(port_a_input_enable)))
      else $error("input bit read not pin level");
   a_digital_cut: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (port_b_digital_en_out & (port_b_direction | ~port_b_input_enable)) == 8'h00 &&
      (port_a_digital_en_out & (port_a_direction | ~port_a_input_enable)) == 8'h00)
      else $error("digital path open on analog pin");
   a_latch_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
      wr_pend && wr_sel == DPAKW_SEL_B_LATCH |=> port_b_output_latch == $past(hwdata_in[7:0]))
      else $error("latch write lost");

endmodule // dpakw_io
`default_nettype wire

/* File: tb/dpakw_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external pins of one port
// ----------------------------------------
module dpakw_pins (
   input  wire logic [7:0] drive_in,
   input  wire logic [7:0] oe_in,
   input  wire logic [7:0] ext_in,
   output logic      [7:0] level_out
);
   // a driven pin shows the device value, an undriven one the outside source
   always_comb begin
      level_out = (oe_in & drive_in) | (~oe_in & ext_in);
   end
endmodule // dpakw_pins
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpakw_cfg.svh"
module tb import dpakw_pkg::*;;
   logic        clk_in, rstn_in, hsel, hwrite, hready, hresp, rd_ph;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  ext_a, ext_b, lvl_a, lvl_b, do_a, oe_a, do_b, oe_b, den_a, den_b, wake;
   logic [7:0]  d, l, e, x, v;
   logic [11:0] base;
   logic [31:0] exp_q[$];
   int          fail_count, n_checks;
   dpakw_io dut (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .port_a_pin_in(lvl_a), .port_b_pin_in(lvl_b),
      .port_a_pin_out(do_a), .port_a_pin_oe_out(oe_a), .port_b_pin_out(do_b), .port_b_pin_oe_out(oe_b),
      .port_a_digital_en_out(den_a), .port_b_digital_en_out(den_b), .key_wakeup_enable_out(wake));
   dpakw_pins pins_a (.drive_in(do_a), .oe_in(oe_a), .ext_in(ext_a), .level_out(lvl_a));
   dpakw_pins pins_b (.drive_in(do_b), .oe_in(oe_b), .ext_in(ext_b), .level_out(lvl_b));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d failures=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one single transfer, then an idle cycle so a following read sees the write
   task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] dat);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= `DPAKW_HTRANS_NONSEQ;
      do @(posedge clk_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, dat};
      do @(posedge clk_in); while (hready !== 1'b1);
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(a, 1'b0, 8'h00);
   endtask
   // ----------------------------------------
   // stimulus and monitor
   // ----------------------------------------
   // clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // read data checked against the oldest note at the end of each read data phase
   always @(posedge clk_in) begin
      if (rd_ph && hready === 1'b1) begin
         chk(hrdata, exp_q.pop_front());
      end
      rd_ph <= hsel && htrans[1] && !hwrite;
   end
   // hang guard
   initial begin
      #(20000 * 50);
      fail_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      {rstn_in, hsel, hwrite} = 3'h0;
      {htrans, haddr, hwdata, ext_a, ext_b} = '0;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(32'h07e7));
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      ext_a <= 8'h5a;
      ext_b <= 8'hc3;
      for (int r = 0; r < 2; r++) begin
         @(posedge clk_in);
         chk({oe_a, oe_b, do_a, do_b}, 32'h0);
         chk({7'h0, hresp, den_a, den_b, wake}, 32'h00ffff00);
         rd(`DPAKW_OFF_A_DIR, 32'h0);
         rd(`DPAKW_OFF_A_INEN, 32'hff);
         rd(`DPAKW_OFF_A_WAKE, 32'h0);
         rd(`DPAKW_OFF_B_INEN, 32'hff);
         rd(`DPAKW_OFF_A_LATCH, {24'h0, ext_a});
         rd(`DPAKW_OFF_B_LATCH, {24'h0, ext_b});
         for (int i = 0; i < 24; i++) begin
            base = (i % 2) ? 12'h010 : 12'h000;
            {d, l, e} = 24'($urandom);
            // outside levels change only while no transfer runs
            ext_a <= 8'($urandom);
            ext_b <= 8'($urandom);
            bus(base, 1'b1, l);
            // no pin stays analog while its direction may turn to output
            bus(base + 12'h008, 1'b1, 8'hff);
            bus(base + 12'h004, 1'b1, d);
            bus(base + 12'h008, 1'b1, e);
            x = (i % 2) ? ext_b : ext_a;
            v = (d & l) | (~d & e & x);
            rd(base, {24'h0, v});
            chk((i % 2) ? {oe_b, do_b, den_b} : {oe_a, do_a, den_a}, {d, l, ~d & e});
            bus(base, 1'b1, v);
            chk((i % 2) ? do_b : do_a, v);
         end
         // wakeup enables exist on the first port only
         bus(`DPAKW_OFF_A_DIR, 1'b1, 8'h00);
         bus(`DPAKW_OFF_A_WAKE, 1'b1, 8'ha5);
         rd(`DPAKW_OFF_A_WAKE, 32'ha5);
         chk({24'h0, wake}, 32'ha5);
         bus(12'h01c, 1'b1, 8'hff);
         rd(12'h01c, 32'h0);
         chk({24'h0, wake}, 32'ha5);
         // second pass starts from a reset in mid-run
         rstn_in <= 1'b0;
         @(posedge clk_in);
         rstn_in <= 1'b1;
         ext_a <= 8'h5a;
         ext_b <= 8'hc3;
      end
      repeat (2) @(posedge clk_in);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
